// ---- design/afcb_cfg.svh ----
// Offsets, reset values and sizes of the filter coefficient byte bank
`ifndef AFCB_CFG_SVH
`define AFCB_CFG_SVH

// Byte offsets on the register page
`define AFCB_ADDR_RDEEMPH_DEN1_HI  7'h33
`define AFCB_ADDR_RDEEMPH_DEN1_LO  7'h34
`define AFCB_ADDR_WIDEN_ATTEN_HI   7'h35
`define AFCB_ADDR_WIDEN_ATTEN_LO   7'h36
`define AFCB_ADDR_RSVD_FIRST       7'h37
`define AFCB_ADDR_RSVD_LAST        7'h40
`define AFCB_ADDR_LHPF_NUM0_HI     7'h41
`define AFCB_ADDR_LHPF_NUM0_LO     7'h42
`define AFCB_ADDR_LHPF_NUM1_HI     7'h43
`define AFCB_ADDR_LHPF_NUM1_LO     7'h44
`define AFCB_ADDR_LHPF_DEN1_HI     7'h45
`define AFCB_ADDR_LHPF_DEN1_LO     7'h46
`define AFCB_ADDR_RHPF_NUM0_HI     7'h47
`define AFCB_ADDR_RHPF_NUM0_LO     7'h48
`define AFCB_ADDR_RHPF_NUM1_HI     7'h49

// Slot index of the first byte of the upper run
`define AFCB_IDX_UPPER_BASE        4'h4

// Reset values
`define AFCB_RST_RDEEMPH_DEN1_HI   8'h53
`define AFCB_RST_RDEEMPH_DEN1_LO   8'h7E
`define AFCB_RST_WIDEN_ATTEN_HI    8'h7F
`define AFCB_RST_WIDEN_ATTEN_LO    8'hFF
`define AFCB_RST_RSVD              8'h00
`define AFCB_RST_HPF_NUM0_HI       8'h39
`define AFCB_RST_HPF_NUM0_LO       8'h55
`define AFCB_RST_HPF_NUM1_HI       8'hF3
`define AFCB_RST_HPF_NUM1_LO       8'h2D
`define AFCB_RST_HPF_DEN1_HI       8'h53
`define AFCB_RST_HPF_DEN1_LO       8'h7E

// Sizes
`define AFCB_BANK_BYTES            13
`define AFCB_ADDR_W                7
`define AFCB_IDX_W                 4

`endif

// ---- design/afcb_pkg.sv ----
// Types shared by the coefficient bank modules
`include "afcb_cfg.svh"
`default_nettype none
package afcb_pkg;
  typedef logic [`AFCB_BANK_BYTES-1:0][7:0] afcb_bytes_t;

  typedef struct packed {
    afcb_bytes_t bytes;
    logic [7:0]  rdata;
  } afcb_store_state_t;

  typedef struct packed {
    logic rd_valid;
    logic rd_zero;
  } afcb_top_state_t;
endpackage
`default_nettype wire

// ---- design/afcb_store_if.sv ----
// Link between the bank decoder and its byte store
`include "afcb_cfg.svh"
`default_nettype none
interface afcb_store_if;
  logic                    wr;
  logic                    rd;
  logic [`AFCB_IDX_W-1:0]  idx;
  logic [7:0]              wdata;
  logic [7:0]              rdata;
  afcb_pkg::afcb_bytes_t   bytes;

  modport ctrl  (output wr, rd, idx, wdata, input rdata, bytes);
  modport store (input wr, rd, idx, wdata, output rdata, bytes);
endinterface
`default_nettype wire

// ---- design/afcb_byte_store.sv ----
// Byte store of the coefficient bank with reset table and registered read
`include "afcb_cfg.svh"
`default_nettype none
module afcb_byte_store (
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   nrst,
  // Decoder side
  afcb_store_if.store sif
);

  localparam afcb_pkg::afcb_bytes_t RST_TABLE = {
    `AFCB_RST_HPF_NUM1_HI,
    `AFCB_RST_HPF_NUM0_LO,     `AFCB_RST_HPF_NUM0_HI,
    `AFCB_RST_HPF_DEN1_LO,     `AFCB_RST_HPF_DEN1_HI,
    `AFCB_RST_HPF_NUM1_LO,     `AFCB_RST_HPF_NUM1_HI,
    `AFCB_RST_HPF_NUM0_LO,     `AFCB_RST_HPF_NUM0_HI,
    `AFCB_RST_WIDEN_ATTEN_LO,  `AFCB_RST_WIDEN_ATTEN_HI,
    `AFCB_RST_RDEEMPH_DEN1_LO, `AFCB_RST_RDEEMPH_DEN1_HI
  };

  afcb_pkg::afcb_store_state_t state_reg;
  afcb_pkg::afcb_store_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // A read in the same cycle as a write returns the old byte
    if (sif.rd) begin
      state_next.rdata = state_reg.bytes[sif.idx];
    end
    if (sif.wr) begin
      state_next.bytes[sif.idx] = sif.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg <= '{bytes: RST_TABLE, rdata: `AFCB_RST_RSVD};
    end else begin
      state_reg <= state_next;
    end
  end

  assign sif.rdata = state_reg.rdata;
  assign sif.bytes = state_reg.bytes;

endmodule
`default_nettype wire

// ---- design/afcb_bank.sv ----
// Filter coefficient register bank: host byte port and coefficient outputs
//
// Notes on behaviour
// - Each high and low byte pair forms one signed 16-bit coefficient.
// - Reserved locations read zero; host never writes them, writes ignored.
// - De-emphasis denominator-one low byte resets to 0x7E.
// - Stereo widening attenuation resets to 0x7FFF, most positive.
// - Left record high-pass numerator-zero resets to 0x3955.
// - Left record high-pass numerator-one resets to 0xF32D.
// - Left record high-pass denominator-one resets to 0x537E.
// - Right record high-pass numerator-zero resets to 0x3955.
// - De-emphasis denominator-one high byte resets to 0x53.
// - Right record high-pass numerator-one high byte resets to 0xF3.
`include "afcb_cfg.svh"
`default_nettype none
module afcb_bank (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  // Host byte port
  input  wire logic [`AFCB_ADDR_W-1:0] reg_addr,
  input  wire logic                    reg_wr_en,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_rd_en,
  output logic      [7:0]              reg_rdata,
  output logic                         reg_rd_valid,
  // Coefficients to the filter datapaths
  output logic signed [15:0]           rdeemph_den1_coef,
  output logic signed [15:0]           widen_atten_coef,
  output logic signed [15:0]           lhpf_num0_coef,
  output logic signed [15:0]           lhpf_num1_coef,
  output logic signed [15:0]           lhpf_den1_coef,
  output logic signed [15:0]           rhpf_num0_coef,
  output logic        [7:0]            rhpf_num1_hi_byte
);

  afcb_store_if sif ();

  afcb_byte_store u_store (
    .core_clk (core_clk),
    .nrst     (nrst),
    .sif      (sif)
  );

  // Maps an offset to a store slot; bit 4 flags a writable byte
  function automatic logic [`AFCB_IDX_W:0] afcb_decode(
    input logic [`AFCB_ADDR_W-1:0] addr
  );
    logic [`AFCB_ADDR_W-1:0] diff;
    diff = '0;
    afcb_decode = '0;
    if (addr >= `AFCB_ADDR_RDEEMPH_DEN1_HI &&
        addr <= `AFCB_ADDR_WIDEN_ATTEN_LO) begin
      diff = addr - `AFCB_ADDR_RDEEMPH_DEN1_HI;
      afcb_decode = {1'b1, diff[`AFCB_IDX_W-1:0]};
    end else if (addr >= `AFCB_ADDR_LHPF_NUM0_HI &&
                 addr <= `AFCB_ADDR_RHPF_NUM1_HI) begin
      diff = addr - `AFCB_ADDR_LHPF_NUM0_HI;
      afcb_decode = {1'b1,
                     diff[`AFCB_IDX_W-1:0] + `AFCB_IDX_UPPER_BASE};
    end
  endfunction

  // Joins a high and low byte into a signed coefficient
  function automatic logic signed [15:0] afcb_join(
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    afcb_join = signed'({hi, lo});
  endfunction

  logic [`AFCB_IDX_W:0]     dec;
  afcb_pkg::afcb_top_state_t state_reg;
  afcb_pkg::afcb_top_state_t state_next;

  assign dec = afcb_decode(reg_addr);

  ////////////////////////////////////////////////////////////////////////////
  // Access control
  always_comb begin
    state_next          = state_reg;
    state_next.rd_valid = reg_rd_en;
    if (reg_rd_en) begin
      state_next.rd_zero = !dec[`AFCB_IDX_W];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg <= '{rd_valid: 1'b0, rd_zero: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign sif.wr    = reg_wr_en && dec[`AFCB_IDX_W];
  assign sif.rd    = reg_rd_en && dec[`AFCB_IDX_W];
  assign sif.idx   = dec[`AFCB_IDX_W-1:0];
  assign sif.wdata = reg_wdata;

  assign reg_rdata    = state_reg.rd_zero ? `AFCB_RST_RSVD : sif.rdata;
  assign reg_rd_valid = state_reg.rd_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Coefficient outputs
  assign rdeemph_den1_coef = afcb_join(sif.bytes[0], sif.bytes[1]);
  assign widen_atten_coef  = afcb_join(sif.bytes[2], sif.bytes[3]);
  assign lhpf_num0_coef    = afcb_join(sif.bytes[4], sif.bytes[5]);
  assign lhpf_num1_coef    = afcb_join(sif.bytes[6], sif.bytes[7]);
  assign lhpf_den1_coef    = afcb_join(sif.bytes[8], sif.bytes[9]);
  assign rhpf_num0_coef    = afcb_join(sif.bytes[10], sif.bytes[11]);
  assign rhpf_num1_hi_byte = sif.bytes[12];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_coef_pair_join: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_wr_en && reg_addr == `AFCB_ADDR_LHPF_NUM1_HI)
      |=> lhpf_num1_coef[15:8] == $past(reg_wdata)
          && lhpf_num1_coef[7:0] == $past(lhpf_num1_coef[7:0]))
    else $error("coefficient high byte not joined from write");

  a_rsvd_reads_zero: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_rd_en && reg_addr >= `AFCB_ADDR_RSVD_FIRST
               && reg_addr <= `AFCB_ADDR_RSVD_LAST)
      |=> reg_rd_valid && reg_rdata == 8'h00)
    else $error("reserved location did not read zero");

  a_deemph_lo_rst: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(nrst) |-> rdeemph_den1_coef[7:0] == 8'h7E)
    else $error("de-emphasis low byte reset wrong");

  a_atten_rst_max: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(nrst) |-> widen_atten_coef == 16'sh7FFF)
    else $error("attenuation reset not most positive");

  a_lnum0_rst_val: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(nrst) |-> lhpf_num0_coef == 16'sh3955)
    else $error("left numerator-zero reset wrong");

  a_lnum1_rst_val: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(nrst) |-> lhpf_num1_coef == 16'shF32D)
    else $error("left numerator-one reset wrong");

  a_lden1_rst_val: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(nrst) |-> lhpf_den1_coef == 16'sh537E)
    else $error("left denominator-one reset wrong");

  a_rnum0_rst_val: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(nrst) |-> rhpf_num0_coef == lhpf_num0_coef
                    && rhpf_num0_coef == 16'sh3955)
    else $error("right numerator-zero reset wrong");

  a_deemph_hi_rst: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(nrst) |-> rdeemph_den1_coef[15:8] == 8'h53)
    else $error("de-emphasis high byte reset wrong");

  a_rnum1_hi_rst: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(nrst) |-> rhpf_num1_hi_byte == 8'hF3)
    else $error("right numerator-one high byte reset wrong");

  a_write_read_back: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_wr_en && dec[`AFCB_IDX_W])
      ##1 (reg_rd_en && !reg_wr_en && reg_addr == $past(reg_addr))
      |=> reg_rd_valid && reg_rdata == $past(reg_wdata, 2))
    else $error("byte did not read back last write");

  a_rst_read_back: assert property (
    @(posedge core_clk) disable iff (!nrst)
    ($rose(nrst) && reg_rd_en && reg_addr == `AFCB_ADDR_WIDEN_ATTEN_LO)
      |=> reg_rdata == 8'hFF)
    else $error("unwritten byte did not read its reset value");

  ////////////////////////////////////////////////////////////////////////////
  // Read port and store checks
  a_rd_valid_pulse: assert property (
    @(posedge core_clk) disable iff (!nrst)
    reg_rd_en |=> reg_rd_valid)
    else $error("read strobe not answered by valid");

  a_rd_valid_idle: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !reg_rd_en |=> !reg_rd_valid)
    else $error("valid raised without a read strobe");

  a_rdata_hold: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !reg_rd_en |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  a_coef_hold: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !reg_wr_en |=> $stable(sif.bytes))
    else $error("stored byte changed without a write");

  a_wr_byte_lands: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_wr_en && dec[`AFCB_IDX_W])
      |=> sif.bytes[$past(sif.idx)] == $past(reg_wdata))
    else $error("written byte did not land in store");

  a_rd_old_byte: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_rd_en && dec[`AFCB_IDX_W])
      |=> reg_rdata == $past(sif.bytes[sif.idx]))
    else $error("mapped read did not return the stored byte");

  a_unmapped_rd_zero: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_rd_en && !dec[`AFCB_IDX_W])
      |=> reg_rd_valid && reg_rdata == `AFCB_RST_RSVD)
    else $error("unmapped location did not read zero");

  a_atten_sign_bit: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_wr_en && reg_addr == `AFCB_ADDR_WIDEN_ATTEN_HI)
      |=> (widen_atten_coef < 16'sh0000) == $past(reg_wdata[7]))
    else $error("coefficient sign does not follow high byte");

endmodule
`default_nettype wire

// ---- testbench/afcb_host_model.sv ----
// Host processor model driving the bank's byte port
`default_nettype none
module afcb_host_model (
  // Clock
  input  wire logic       core_clk,
  // Byte port
  output logic      [6:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd_en,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr  = 7'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One request per cycle; idle lines show a changing pattern, not old values
  task automatic op(input logic w, input logic r, input logic [6:0] a,
                    input logic [7:0] d, output logic [7:0] q,
                    output logic v);
    reg_wr_en = w;
    reg_rd_en = r;
    reg_addr  = (w | r) ? a : ~reg_addr;
    reg_wdata = w ? d : ~reg_wdata;
    @(posedge core_clk);
    #1;
    q = reg_rdata;
    v = reg_rd_valid;
  endtask
endmodule
`default_nettype wire

// ---- testbench/afcb_bank_tb_top.sv ----
// Self-checking bench of the filter coefficient bank
`default_nettype none
module afcb_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic               core_clk = 1'b0;
  logic               nrst = 1'b0;
  logic        [6:0]  reg_addr;
  logic               reg_wr_en;
  logic               reg_rd_en;
  logic               reg_rd_valid;
  logic        [7:0]  reg_wdata;
  logic        [7:0]  reg_rdata;
  logic signed [15:0] rdeemph_den1_coef, widen_atten_coef, lhpf_num0_coef;
  logic signed [15:0] lhpf_num1_coef, lhpf_den1_coef, rhpf_num0_coef;
  logic        [7:0]  rhpf_num1_hi_byte;
  logic        [7:0]  em [0:127];
  logic        [31:0] seed = 32'h8;
  int                 fails = 0;
  int                 n_checks = 0;

  always #12.5 core_clk = ~core_clk;

  afcb_bank i_afcb_bank (.core_clk, .nrst, .reg_addr, .reg_wr_en,
    .reg_wdata, .reg_rd_en, .reg_rdata, .reg_rd_valid, .rdeemph_den1_coef,
    .widen_atten_coef, .lhpf_num0_coef, .lhpf_num1_coef, .lhpf_den1_coef,
    .rhpf_num0_coef, .rhpf_num1_hi_byte);
  afcb_host_model i_afcb_host_model (.core_clk, .reg_addr, .reg_wr_en,
    .reg_wdata, .reg_rd_en, .reg_rdata, .reg_rd_valid);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rst_val(input logic [6:0] a);
    case (a)
      7'h33, 7'h45: return 8'h53;
      7'h34, 7'h46: return 8'h7E;
      7'h35:        return 8'h7F;
      7'h36:        return 8'hFF;
      7'h41, 7'h47: return 8'h39;
      7'h42, 7'h48: return 8'h55;
      7'h43, 7'h49: return 8'hF3;
      7'h44:        return 8'h2D;
      default:      return 8'h00;
    endcase
  endfunction

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic coefs();
    chk(rdeemph_den1_coef, {em[7'h33], em[7'h34]});
    chk(widen_atten_coef, {em[7'h35], em[7'h36]});
    chk(lhpf_num0_coef, {em[7'h41], em[7'h42]});
    chk(lhpf_num1_coef, {em[7'h43], em[7'h44]});
    chk(lhpf_den1_coef, {em[7'h45], em[7'h46]});
    chk(rhpf_num0_coef, {em[7'h47], em[7'h48]});
    chk({8'h00, rhpf_num1_hi_byte}, {8'h00, em[7'h49]});
  endtask

  // Writes go to mapped bytes only
  task automatic op(input logic w, input logic r, input logic [6:0] a,
                    input logic [7:0] d);
    logic [7:0] q;
    logic       v;
    logic [7:0] e;
    e = em[a];
    i_afcb_host_model.op(w, r, a, d, q, v);
    if (w) em[a] = d;
    chk({8'h00, q & {8{r}}}, {8'h00, e & {8{r}}});
    chk({15'h0000, v}, {15'h0000, r});
    coefs();
  endtask

  task automatic do_rst();
    nrst = 1'b0;
    repeat (6) @(posedge core_clk);
    #1 nrst = 1'b1;
    for (int a = 0; a < 128; a++) em[a] = rst_val(a[6:0]);
  endtask

  task automatic end_sim();
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [3:0]  k;
    logic [6:0]  a;
    do_rst();
    coefs();
    op(1'b0, 1'b1, 7'h36, 8'h00);
    for (int i = 'h30; i < 'h50; i++) op(1'b0, 1'b1, i[6:0], 8'h00);
    op(1'b1, 1'b0, 7'h35, 8'h80);
    op(1'b1, 1'b0, 7'h36, 8'h00);
    chk({15'h0000, widen_atten_coef < 0}, 16'h0001);
    op(1'b1, 1'b0, 7'h41, 8'h12);
    op(1'b0, 1'b1, 7'h41, 8'h00);
    for (int i = 0; i < 400; i++) begin
      r = xs();
      k = 4'(r[7:0] % 13);
      a = (k < 4) ? 7'h33 + 7'(k) : 7'h3D + 7'(k);
      if (r[9:8] == 2'b01) a = r[16:10];
      op(r[9:8] != 2'b01, r[9] ^ r[8], a, r[31:24]);
    end
    op(1'b0, 1'b0, 7'h00, 8'h00);
    do_rst();
    coefs();
    op(1'b0, 1'b1, 7'h36, 8'h00);
    end_sim();
  end

  initial begin
    #100000;
    fails++;
    end_sim();
  end
endmodule
`default_nettype wire
